// File: core/mepc_pkg.sv
// Package of constants for the motor encoder and phase configuration block
package mepc_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] MEPC_CTRL_ADDR    = 8'h00;
	localparam logic [7:0] MEPC_STEPS_ADDR   = 8'h04;
	localparam logic [7:0] MEPC_TOPSPD_ADDR  = 8'h08;
	localparam logic [7:0] MEPC_STAT_ADDR    = 8'h0C;
	localparam logic [7:0] MEPC_IRQ_ST_ADDR  = 8'h10;
	localparam logic [7:0] MEPC_IRQ_EN_ADDR  = 8'h14;
	localparam logic [7:0] MEPC_IRQ_CLR_ADDR = 8'h18;
	localparam logic [7:0] MEPC_POS_ADDR     = 8'h1C;
	localparam logic [7:0] MEPC_SPEED_ADDR   = 8'h20;
	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	localparam int MEPC_CTRL_INV_BIT   = 0;
	localparam int MEPC_CTRL_SWAP_BIT  = 1;
	localparam int MEPC_CTRL_CHECK_BIT = 2;
	localparam int MEPC_CTRL_LIMP_BIT  = 3;
	localparam int MEPC_CTRL_RUN_BIT   = 4;
	// Interrupt status bits
	localparam int MEPC_IRQ_PCF_BIT = 0;
	localparam int MEPC_IRQ_ENC_BIT = 1;
	// ----------------------------------------------------------------
	// Ranges and reset values
	// ----------------------------------------------------------------
	localparam logic [8:0]  MEPC_STEPS_MIN    = 9'h004;
	localparam logic [8:0]  MEPC_STEPS_MAX    = 9'h100;
	localparam logic [8:0]  MEPC_STEPS_RST    = 9'h040;
	localparam logic [12:0] MEPC_TOPSPD_MIN   = 13'h01F4;
	localparam logic [12:0] MEPC_TOPSPD_MAX   = 13'h1770;
	localparam logic [12:0] MEPC_TOPSPD_RST   = 13'h0BB8;
	// Speed gate window and encoder timeout
	localparam int MEPC_WINDOW_US    = 10000;
	localparam int MEPC_CLK_MHZ      = 20;
	localparam int MEPC_WINDOW_CYC   = MEPC_WINDOW_US * MEPC_CLK_MHZ;
	localparam int MEPC_ENC_TMO_WIN  = 50;
endpackage : mepc_pkg

// File: core/mepc_top.sv
// Encoder direction, phase order, pulse count and encoder supervision with AHB-Lite registers
`timescale 1ns/1ns
`default_nettype none
module mepc_top
	import mepc_pkg::*;
#(
	parameter int WINDOW_CYC = MEPC_WINDOW_CYC
)(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Encoder quadrature inputs
	input  wire logic        enc_a,
	input  wire logic        enc_b,
	// Phase commands from the modulator, outputs to the power stage
	input  wire logic [2:0]  phase_cmd,
	output logic [2:0]       phase_out,
	// Drive control
	output logic             drive_enable,
	output logic             limp_home_operation,
	output logic             irq
);
	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [7:0]  addr_q;
	logic        wr_q;
	logic        rd_q;
	logic        ctrl_inv;
	logic        ctrl_swap;
	logic        encoder_failure_check_on;
	logic        ctrl_limp;
	logic        ctrl_run;
	logic [8:0]  steps;
	logic [12:0] top_speed;
	logic [1:0]  irq_st;
	logic [1:0]  irq_en;
	logic        param_fault;
	logic        enc_failed;
	logic signed [15:0] position;
	logic signed [15:0] speed;

	wire access  = hsel & hready & htrans[1];
	wire wr_ctrl = wr_q & (addr_q == MEPC_CTRL_ADDR);
	wire wr_stp  = wr_q & (addr_q == MEPC_STEPS_ADDR);
	wire wr_top  = wr_q & (addr_q == MEPC_TOPSPD_ADDR);
	wire wr_en   = wr_q & (addr_q == MEPC_IRQ_EN_ADDR);
	wire wr_clr  = wr_q & (addr_q == MEPC_IRQ_CLR_ADDR);

	// Zero-wait slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 8'h00;
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
		end else begin
			addr_q <= haddr;
			wr_q   <= access & hwrite;
			rd_q   <= access & ~hwrite;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Out-of-range steps and top speed are clamped so the math stays sane
	wire [8:0]  wr_steps = (hwdata[8:0] < MEPC_STEPS_MIN) ? MEPC_STEPS_MIN :
		(hwdata[8:0] > MEPC_STEPS_MAX) ? MEPC_STEPS_MAX : hwdata[8:0];
	wire [12:0] wr_top_v = (hwdata[12:0] < MEPC_TOPSPD_MIN) ? MEPC_TOPSPD_MIN :
		(hwdata[12:0] > MEPC_TOPSPD_MAX) ? MEPC_TOPSPD_MAX : hwdata[12:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_inv                 <= 1'b0;
			ctrl_swap                <= 1'b0;
			encoder_failure_check_on <= 1'b0;
			ctrl_limp                <= 1'b0;
			ctrl_run                 <= 1'b0;
			steps                    <= MEPC_STEPS_RST;
			top_speed                <= MEPC_TOPSPD_RST;
			irq_en                   <= 2'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_inv                 <= hwdata[MEPC_CTRL_INV_BIT];
				ctrl_swap                <= hwdata[MEPC_CTRL_SWAP_BIT];
				encoder_failure_check_on <= hwdata[MEPC_CTRL_CHECK_BIT];
				ctrl_limp                <= hwdata[MEPC_CTRL_LIMP_BIT];
				ctrl_run                 <= hwdata[MEPC_CTRL_RUN_BIT];
			end
			if (wr_stp)
				steps <= wr_steps;
			if (wr_top)
				top_speed <= wr_top_v;
			if (wr_en)
				irq_en <= hwdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Phase output and powered detection
	// ----------------------------------------------------------------
	// Swapping V and W reverses the rotating field sequence
	assign phase_out = ctrl_swap ? {phase_cmd[1], phase_cmd[2], phase_cmd[0]}
		: phase_cmd;

	logic [2:0] phase_q;
	logic [7:0] idle_cnt;
	logic       powered;
	// Powered while drive is enabled and any phase toggled in the last 256 cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q  <= 3'h0;
			idle_cnt <= 8'hFF;
		end else begin
			phase_q  <= phase_cmd;
			idle_cnt <= (phase_q != phase_cmd) ? 8'h00 :
				((idle_cnt == 8'hFF) ? idle_cnt : idle_cnt + 8'h01);
		end
	end
	assign powered = (idle_cnt != 8'hFF) & drive_enable;

	// ----------------------------------------------------------------
	// Parameter change fault
	// ----------------------------------------------------------------
	// Only hresetn (power cycle) clears it; software has no path to undo it
	wire cfg_change = (wr_ctrl & ((hwdata[MEPC_CTRL_INV_BIT] != ctrl_inv) |
		(hwdata[MEPC_CTRL_SWAP_BIT] != ctrl_swap))) |
		(wr_stp & (wr_steps != steps));
	wire pcf_set = cfg_change & powered;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			param_fault <= 1'b0;
		else if (pcf_set)
			param_fault <= 1'b1;
	end
	// A latched fault must keep the power stage off until the next power cycle
	a_fault_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
		param_fault |-> !drive_enable) else $error("drive on with parameter fault");

	// ----------------------------------------------------------------
	// Quadrature decode
	// ----------------------------------------------------------------
	logic [1:0] ab_q;
	logic       ab_valid;
	// The first sample after reset only loads the history, so a shaft resting
	// away from the all-zero state does not count a false step
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ab_q     <= 2'b00;
			ab_valid <= 1'b0;
		end else begin
			ab_q     <= {enc_a, enc_b};
			ab_valid <= 1'b1;
		end
	end
	wire ab_moved = ab_valid & (ab_q != {enc_a, enc_b});
	wire raw_fwd  = ab_q[1] ^ enc_b;
	// Invert flips the effective rotation sense
	wire step_fwd = raw_fwd ^ ctrl_inv;

	// ----------------------------------------------------------------
	// Position, speed gate and encoder supervision
	// ----------------------------------------------------------------
	logic [31:0]        win_cnt;
	logic signed [15:0] win_acc;
	logic [7:0]         quiet_win;
	wire win_end = (win_cnt == WINDOW_CYC - 1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			position  <= 16'sh0000;
			win_cnt   <= 32'h0000_0000;
			win_acc   <= 16'sh0000;
			speed     <= 16'sh0000;
			quiet_win <= 8'h00;
		end else begin
			if (ab_moved)
				position <= step_fwd ? position + 16'sh0001
					: position - 16'sh0001;
			win_cnt <= win_end ? 32'h0000_0000 : win_cnt + 32'h0000_0001;
			if (win_end) begin
				// Speed in rpm = counts * 6000 / (4 * steps), per 10 ms window
				speed   <= 16'(($signed(32'(win_acc)) * 32'sd1500) /
					$signed({23'h0, steps}));
				win_acc <= 16'sh0000;
				quiet_win <= (powered && win_acc == 16'sh0000 &&
					quiet_win != 8'hFF) ? quiet_win + 8'h01 :
					(powered ? quiet_win : 8'h00);
			end else if (ab_moved) begin
				win_acc <= step_fwd ? win_acc + 16'sh0001 : win_acc - 16'sh0001;
				quiet_win <= 8'h00;
			end
		end
	end

	// Powered yet silent encoder for a run of windows means failure
	wire enc_fail_now = encoder_failure_check_on &&
		(quiet_win >= 8'(MEPC_ENC_TMO_WIN));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			enc_failed <= 1'b0;
		else if (!encoder_failure_check_on)
			enc_failed <= 1'b0;
		else if (enc_fail_now)
			enc_failed <= 1'b1;
	end
	// Detection must latch the failure on the very next edge
	a_enc_fail_set: assert property (@(posedge hclk) disable iff (!hresetn)
		enc_fail_now |=> enc_failed) else $error("encoder failure not latched");

	// Drive permission: fault stops, limp home keeps a reduced drive
	assign limp_home_operation = enc_failed & ctrl_limp;
	assign drive_enable = ctrl_run & ~param_fault &
		(~enc_failed | ctrl_limp);
	// Limp home keeps a reduced drive alive after the encoder is lost
	a_limp_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		enc_failed && ctrl_limp && ctrl_run && !param_fault |->
		drive_enable && limp_home_operation) else $error("limp home drive lost");

	// ----------------------------------------------------------------
	// Interrupts: status set wins over clear
	// ----------------------------------------------------------------
	wire [1:0] ev = {enc_fail_now & ~enc_failed, pcf_set};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_st <= 2'h0;
		else
			irq_st <= ev | (irq_st & ~(wr_clr ? hwdata[1:0] : 2'h0));
	end
	assign irq = |(irq_st & irq_en);
	// A fault event must reach status even when a clear lands in the same cycle
	a_pcf_status: assert property (@(posedge hclk) disable iff (!hresetn)
		pcf_set |=> irq_st[MEPC_IRQ_PCF_BIT]) else $error("fault event lost");

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	wire [31:0] ctrl_rd = {27'h0, ctrl_run, ctrl_limp, encoder_failure_check_on,
		ctrl_swap, ctrl_inv};
	wire [31:0] rd_mux =
		(addr_q == MEPC_CTRL_ADDR)   ? ctrl_rd :
		(addr_q == MEPC_STEPS_ADDR)  ? {23'h0, steps} :
		(addr_q == MEPC_TOPSPD_ADDR) ? {19'h0, top_speed} :
		(addr_q == MEPC_STAT_ADDR)   ? {27'h0, limp_home_operation, drive_enable,
			powered, enc_failed, param_fault} :
		(addr_q == MEPC_IRQ_ST_ADDR) ? {30'h0, irq_st} :
		(addr_q == MEPC_IRQ_EN_ADDR) ? {30'h0, irq_en} :
		(addr_q == MEPC_POS_ADDR)    ? {{16{position[15]}}, position} :
		(addr_q == MEPC_SPEED_ADDR)  ? {{16{speed[15]}}, speed} : 32'h0000_0000;
	assign hrdata = rd_q ? rd_mux : 32'h0000_0000;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_fault_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		param_fault |=> param_fault) else $error("parameter fault cleared");
	a_fault_on_change: assert property (@(posedge hclk) disable iff (!hresetn)
		pcf_set |=> param_fault && !drive_enable) else $error("fault not raised");
	a_phase_swap: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_swap |-> phase_out[2] == phase_cmd[1] && phase_out[1] == phase_cmd[2])
		else $error("phase swap wrong");
	a_phase_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		!ctrl_swap |-> phase_out == phase_cmd) else $error("phase pass wrong");
	a_steps_range: assert property (@(posedge hclk) disable iff (!hresetn)
		steps >= MEPC_STEPS_MIN && steps <= MEPC_STEPS_MAX) else $error("steps range");
	a_top_range: assert property (@(posedge hclk) disable iff (!hresetn)
		top_speed >= MEPC_TOPSPD_MIN && top_speed <= MEPC_TOPSPD_MAX)
		else $error("top speed range");
	a_dir_invert: assert property (@(posedge hclk) disable iff (!hresetn)
		ab_moved && (raw_fwd ^ ctrl_inv) |=> position == $past(position) + 16'sh0001)
		else $error("direction sense wrong");
	a_enc_fail_off: assert property (@(posedge hclk) disable iff (!hresetn)
		!encoder_failure_check_on |=> !enc_failed) else $error("check ran while off");
	a_enc_drive_off: assert property (@(posedge hclk) disable iff (!hresetn)
		enc_failed && !ctrl_limp |-> !drive_enable) else $error("drive on after failure");
	a_powered_switch: assert property (@(posedge hclk) disable iff (!hresetn)
		phase_cmd != $past(phase_cmd) |=> powered == drive_enable)
		else $error("powered flag wrong");
endmodule : mepc_top
`default_nettype wire

// File: tb/mepc_motor_model.sv
// Model of the shaft encoder and the phase modulator beside the block
`timescale 1ns/1ns
`default_nettype none
module mepc_motor_model (
	// Clock and test controls
	input  wire logic      hclk,
	input  wire logic      spin,
	input  wire logic      backward,
	// Drive permission from the block
	input  wire logic      drive_enable,
	// Encoder levels and phase commands
	output var logic       enc_a,
	output var logic       enc_b,
	output var logic [2:0] phase_cmd
);
	logic [3:0] div  = 4'h0;
	logic [1:0] quad = 2'h0;
	logic [2:0] ring = 3'h0;
	// Shaft steps every 16 cycles; phases rotate only while drive is allowed
	always @(posedge hclk) begin
		div <= div + 4'h1;
		if (spin && div == 4'hF) begin
			quad <= backward ? quad - 2'h1 : quad + 2'h1;
		end
		if (drive_enable && div[2:0] == 3'h7) begin
			ring <= {ring[1:0], ~ring[2]};
		end
	end
	// Gray coding, so only one encoder line moves per step
	assign enc_a = quad[1];
	assign enc_b = quad[1] ^ quad[0];
	// One driver for the phase commands
	assign phase_cmd = ring;
endmodule : mepc_motor_model
`default_nettype wire

// File: tb/mepc_top_test.sv
// Self-checking bench for the encoder and phase configuration block
`timescale 1ns/1ns
`default_nettype none
module mepc_top_test
	import mepc_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	localparam int WIN = 100;
	logic        hclk     = 1'b0;
	logic        hresetn  = 1'b0;
	logic        hsel     = 1'b0;
	logic [7:0]  haddr    = 8'h00;
	logic [1:0]  htrans   = 2'h0;
	logic        hwrite   = 1'b0;
	logic [31:0] hwdata   = 32'h0;
	logic        spin     = 1'b0;
	logic        backward = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        enc_a;
	logic        enc_b;
	logic [2:0]  phase_cmd;
	logic [2:0]  phase_out;
	logic        drive_enable;
	logic        limp_home_operation;
	logic        irq;
	logic [31:0] rd;
	logic [31:0] p0;
	int          miscompares = 0;
	int          n_compared  = 0;
	// Clock of 50 ns period
	always #25 hclk = ~hclk;
	// A short speed window keeps the encoder timeout within reach
	mepc_top #(.WINDOW_CYC(WIN)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.enc_a(enc_a), .enc_b(enc_b), .phase_cmd(phase_cmd), .phase_out(phase_out),
		.drive_enable(drive_enable), .limp_home_operation(limp_home_operation), .irq(irq));
	mepc_motor_model u_motor (.hclk(hclk), .spin(spin), .backward(backward),
		.drive_enable(drive_enable), .enc_a(enc_a), .enc_b(enc_b), .phase_cmd(phase_cmd));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic complete_run;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run
	// Reset stands in for a power cycle, the only way out of a latched fault
	task automatic do_reset;
		@(posedge hclk);
		hresetn <= 1'b0;
		spin <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
	endtask : do_reset
	// Single word transfer; waits on ready rather than assuming zero wait
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		hsel <= 1'b0;
	endtask : bus
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_limits;
		do_reset();
		bus(1'b0, MEPC_STEPS_ADDR, 32'h0, rd);
		check(rd, {23'h0, MEPC_STEPS_RST});
		bus(1'b0, MEPC_TOPSPD_ADDR, 32'h0, rd);
		check(rd, {19'h0, MEPC_TOPSPD_RST});
		bus(1'b1, MEPC_STEPS_ADDR, 32'h3, rd);
		bus(1'b0, MEPC_STEPS_ADDR, 32'h0, rd);
		check(rd, {23'h0, MEPC_STEPS_MIN});
		bus(1'b1, MEPC_STEPS_ADDR, 32'h101, rd);
		bus(1'b0, MEPC_STEPS_ADDR, 32'h0, rd);
		check(rd, {23'h0, MEPC_STEPS_MAX});
		bus(1'b1, MEPC_TOPSPD_ADDR, 32'h1F3, rd);
		bus(1'b0, MEPC_TOPSPD_ADDR, 32'h0, rd);
		check(rd, {19'h0, MEPC_TOPSPD_MIN});
		bus(1'b1, MEPC_TOPSPD_ADDR, 32'h1771, rd);
		bus(1'b0, MEPC_TOPSPD_ADDR, 32'h0, rd);
		check(rd, {19'h0, MEPC_TOPSPD_MAX});
		bus(1'b0, MEPC_IRQ_ST_ADDR, 32'h0, rd);
		check(rd, 32'h0);
		bus(1'b0, 8'h3C, 32'h0, rd);
		check(rd, 32'h0);
		check({31'h0, hresp}, 32'h0);
	endtask : t_reset_limits
	// Swap set in the same write as run, then withdrawn while powered
	task automatic t_swap_fault;
		do_reset();
		bus(1'b1, MEPC_IRQ_EN_ADDR, 32'h3, rd);
		bus(1'b1, MEPC_CTRL_ADDR, 32'h12, rd);
		repeat (12) begin
			@(negedge hclk);
			check({29'h0, phase_out}, {29'h0, phase_cmd[1], phase_cmd[2], phase_cmd[0]});
		end
		check({31'h0, drive_enable}, 32'h1);
		bus(1'b0, MEPC_STAT_ADDR, 32'h0, rd);
		check(rd & 32'h4, 32'h4);
		bus(1'b1, MEPC_CTRL_ADDR, 32'h10, rd);
		@(negedge hclk);
		check({30'h0, drive_enable, irq}, 32'h1);
		bus(1'b1, MEPC_IRQ_CLR_ADDR, 32'h1, rd);
		bus(1'b0, MEPC_STAT_ADDR, 32'h0, rd);
		check(rd & 32'h1, 32'h1);
		check({31'h0, irq}, 32'h0);
		do_reset();
		bus(1'b0, MEPC_STAT_ADDR, 32'h0, rd);
		check(rd & 32'h1, 32'h0);
	endtask : t_swap_fault
	// Pulse count, then invert, changed while powered; a same-value write is harmless
	task automatic t_steps_fault;
		do_reset();
		bus(1'b1, MEPC_CTRL_ADDR, 32'h10, rd);
		repeat (20) @(posedge hclk);
		bus(1'b1, MEPC_STEPS_ADDR, 32'h40, rd);
		bus(1'b0, MEPC_IRQ_ST_ADDR, 32'h0, rd);
		check(rd, 32'h0);
		bus(1'b1, MEPC_STEPS_ADDR, 32'h80, rd);
		bus(1'b0, MEPC_IRQ_ST_ADDR, 32'h0, rd);
		check(rd, 32'h1);
		do_reset();
		bus(1'b1, MEPC_CTRL_ADDR, 32'h10, rd);
		repeat (20) @(posedge hclk);
		bus(1'b1, MEPC_CTRL_ADDR, 32'h11, rd);
		bus(1'b0, MEPC_STAT_ADDR, 32'h0, rd);
		check(rd & 32'h1, 32'h1);
	endtask : t_steps_fault
	// Shaft turns backward; invert makes that report as positive
	task automatic t_direction;
		do_reset();
		bus(1'b1, MEPC_STEPS_ADDR, 32'h40, rd);
		backward <= 1'b1;
		spin <= 1'b1;
		repeat (3 * WIN) @(posedge hclk);
		bus(1'b0, MEPC_SPEED_ADDR, 32'h0, rd);
		check({31'h0, rd[31]}, 32'h1);
		bus(1'b1, MEPC_CTRL_ADDR, 32'h1, rd);
		repeat (3 * WIN) @(posedge hclk);
		bus(1'b0, MEPC_SPEED_ADDR, 32'h0, rd);
		check({31'h0, rd[31] | (rd == 32'h0)}, 32'h0);
		bus(1'b0, MEPC_POS_ADDR, 32'h0, p0);
		repeat (WIN) @(posedge hclk);
		bus(1'b0, MEPC_POS_ADDR, 32'h0, rd);
		check({31'h0, $signed(rd - p0) > 0}, 32'h1);
	endtask : t_direction
	// Dead encoder with the check on, then limp home, then check off
	task automatic t_enc_fail;
		do_reset();
		bus(1'b1, MEPC_IRQ_EN_ADDR, 32'h2, rd);
		bus(1'b1, MEPC_CTRL_ADDR, 32'h14, rd);
		repeat (48 * WIN) @(posedge hclk);
		check({31'h0, drive_enable}, 32'h1);
		repeat (4 * WIN) @(negedge hclk);
		check({30'h0, drive_enable, irq}, 32'h1);
		bus(1'b1, MEPC_CTRL_ADDR, 32'h1C, rd);
		@(negedge hclk);
		check({30'h0, drive_enable, limp_home_operation}, 32'h3);
		bus(1'b1, MEPC_CTRL_ADDR, 32'h18, rd);
		// The failure flag drops one edge after the check bit goes off
		repeat (2) @(negedge hclk);
		check({30'h0, drive_enable, limp_home_operation}, 32'h2);
	endtask : t_enc_fail
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		t_reset_limits();
		t_swap_fault();
		t_steps_fault();
		t_direction();
		t_enc_fail();
		complete_run();
	end
	// The run needs under 9000 cycles, so this margin flags only a hang
	initial begin
		repeat (20000) @(posedge hclk);
		miscompares++;
		complete_run();
	end
endmodule : mepc_top_test
`default_nettype wire
